// >>> rtl/swc_pkg.sv
// Shared constants and types of the sleep and wake-up controller.
// Assumes a single 25 MHz clock and an APB register port.
`default_nettype none
package swc_pkg;
  // ==========================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVT_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'h10;
  // ==========================================================
  // Control field layout and reset value.
  localparam int CTL_W = 7;
  localparam int CTL_OSC_LSB = 0;
  localparam int CTL_OSC_MSB = 2;
  localparam int CTL_WDT_EN = 3;
  localparam int CTL_EDGE_EN = 4;
  localparam int CTL_PORT_EN = 5;
  localparam int CTL_ADC_EN = 6;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h09;
  // ==========================================================
  // State word and event bits.
  localparam int ST_PD = 0;
  localparam int ST_TO = 1;
  localparam int ST_ASLEEP = 2;
  localparam int ST_START = 3;
  localparam int EVT_W = 4;
  localparam int EVT_SLEEP = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_WDT_RST = 2;
  localparam int EVT_EXT_RST = 3;
  // ==========================================================
  // Oscillator mode codes.
  localparam logic [2:0] OSC_LOW_POWER = 3'h0;
  localparam logic [2:0] OSC_CRYSTAL = 3'h1;
  localparam logic [2:0] OSC_HIGH_SPEED = 3'h2;
  localparam logic [2:0] OSC_EXTERNAL_RC = 3'h3;
  localparam logic [2:0] OSC_INTERNAL_RC = 3'h4;
  // ==========================================================
  // Oscillator start-up delay, in oscillator periods.
  localparam int OST_TOSC = 1024;
  localparam int TOSC_NS = 40;
  localparam int CLK_NS = 40;
  localparam int OST_W = 11;
  localparam logic [OST_W-1:0] OST_CYCLES =
    OST_W'((OST_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [OST_W-1:0] OST_LAST = 11'h001;
  localparam int PORT_W = 6;
  typedef enum logic [1:0] {
    SWC_AWAKE, SWC_ASLEEP, SWC_START_UP, SWC_RESUME
  } swc_state_t;
endpackage
`default_nettype wire

// >>> rtl/swc_ost_timer.sv
// Oscillator start-up delay counter.
// Assumes start is a one-cycle pulse given while the timer is idle.
`default_nettype none
module swc_ost_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic done
);
  // Cycles still to wait; zero when idle.
  logic [swc_pkg::OST_W-1:0] remain;

  // ==========================================================
  // Counting.
  // A load followed by a countdown gives done exactly
  // OST_CYCLES edges after the start pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain <= '0;
      done <= 1'b0;
    end else if (start) begin
      remain <= swc_pkg::OST_CYCLES;
      done <= 1'b0;
    end else begin
      done <= (remain == swc_pkg::OST_LAST);
      if (remain != '0) begin
        remain <= remain - swc_pkg::OST_LAST;
      end
    end
  end
endmodule // swc_ost_timer
`default_nettype wire

// >>> rtl/swc_port_hold.sv
// Port drive latch that freezes pin state while the device sleeps.
// Assumes the core's port value and enables are synchronous to clk.
`default_nettype none
module swc_port_hold (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [swc_pkg::PORT_W-1:0] core_out,
  input wire logic [swc_pkg::PORT_W-1:0] core_oe,
  output logic [swc_pkg::PORT_W-1:0] port_out,
  output logic [swc_pkg::PORT_W-1:0] port_oe
);
  // ==========================================================
  // Latch.
  // Holding the enables as well as the values keeps a pin that was
  // high impedance floating instead of driving it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_out <= '0;
      port_oe <= '0;
    end else if (!hold) begin
      port_out <= core_out;
      port_oe <= core_oe;
    end
  end
endmodule // swc_port_hold
`default_nettype wire

// >>> rtl/swc_top.sv
// Sleep entry, wake-up and status-flag control for a small core.
// Assumes core strobes are one-cycle pulses synchronous to clk, the
// watchdog runs elsewhere and reports time-outs as pulses.
// Notes on behaviour
// - Sleep clears watchdog, PD low, TO high, oscillator off.
// - Port drive state frozen during sleep.
// - Wake on reset pin, watchdog, enabled interrupts.
// - Reset pin resets; other sources simply resume.
// - PD set at power-up, cleared by sleep.
// - Watchdog time-out clears TO, also when waking.
// - Converter wakes only when on RC clock.
// - Sleep prefetches the next instruction.
// - Enabled source wakes regardless of global enable.
// - Resume then vector only if global enable set.
// - Pending enabled flag, global off: sleep is no-op.
// - Flag arriving during sleep: complete, then wake.
// - Crystal modes wait start-up delay; RC modes not.
// - Awake watchdog time-out resets the device.
`default_nettype none
module swc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic wdt_timeout,
  input wire logic global_irq_enable,
  input wire logic external_reset_pin_n,
  input wire logic edge_irq_flag,
  input wire logic port_change_flag,
  input wire logic adc_done_flag,
  input wire logic adc_rc_clock,
  input wire logic [swc_pkg::PORT_W-1:0] core_port_out,
  input wire logic [swc_pkg::PORT_W-1:0] core_port_oe,
  output logic [swc_pkg::PORT_W-1:0] port_out,
  output logic [swc_pkg::PORT_W-1:0] port_oe,
  output logic power_down_flag,
  output logic timeout_flag,
  output logic osc_driver_on,
  output logic phase_clk_en,
  output logic prefetch_next,
  output logic resume_exec,
  output logic branch_to_vector,
  output logic wdt_clear,
  output logic device_reset_req,
  output logic irq
);
  // ==========================================================
  // Helper functions.
  // True when an enabled interrupt flag is set; the converter only
  // counts in sleep when it runs from its own RC clock.
  function automatic logic pending(input logic [swc_pkg::CTL_W-1:0] c,
                                   input logic asleep);
    logic adc_ok;
    adc_ok = adc_done_flag && c[swc_pkg::CTL_ADC_EN] &&
             (adc_rc_clock || !asleep);
    pending = (edge_irq_flag && c[swc_pkg::CTL_EDGE_EN]) ||
              (port_change_flag && c[swc_pkg::CTL_PORT_EN]) || adc_ok;
  endfunction
  // Crystal and resonator modes need the start-up delay.
  function automatic logic needs_ost(input logic [2:0] mode);
    needs_ost = (mode == swc_pkg::OSC_LOW_POWER) ||
                (mode == swc_pkg::OSC_CRYSTAL) ||
                (mode == swc_pkg::OSC_HIGH_SPEED);
  endfunction

  // ==========================================================
  // Declarations.
  swc_pkg::swc_state_t state; // Sleep sequencer state.
  logic [swc_pkg::CTL_W-1:0] control; // Software control word.
  logic [swc_pkg::EVT_W-1:0] evt_status; // Sticky events.
  logic [swc_pkg::EVT_W-1:0] evt_enable; // Interrupt mask.
  logic ext_prev; // Reset pin level one cycle ago.
  logic ext_fall; // Reset pin asserted this cycle.
  logic wdt_to_ev; // Enabled watchdog time-out.
  logic sleep_seen; // Sleep instruction while awake.
  logic sleep_nop; // Sleep that must act as a no-op.
  logic sleep_ok; // Sleep that is not a no-op; enters power-down unless wdt_reset.
  logic wake_irq; // Enabled interrupt while asleep.
  logic wdt_wake; // Watchdog time-out while asleep.
  logic wdt_reset; // Watchdog time-out while running.
  logic wake; // Any non-reset wake source while asleep.
  logic ost_start; // Start the oscillator delay.
  logic ost_done; // Oscillator delay elapsed.
  logic apb_access; // Completing APB transfer.
  logic apb_write; // Completing APB write.
  logic [swc_pkg::EVT_W-1:0] evt_set; // Events this cycle.
  logic [swc_pkg::EVT_W-1:0] evt_clr; // Clear mask this cycle.
  logic [31:0] next_rdata; // Read mux output.
  logic next_err; // Unmapped address.

  // ==========================================================
  // Event decoding.
  assign ext_fall = ext_prev && !external_reset_pin_n;
  assign wdt_to_ev = wdt_timeout && control[swc_pkg::CTL_WDT_EN];
  assign sleep_seen = sleep_instr && (state == swc_pkg::SWC_AWAKE);
  // Only always_comb wakes on the flags that the function reads itself.
  always_comb begin
    sleep_nop = sleep_seen && !global_irq_enable &&
                pending(control, 1'b0);
    wake_irq = (state == swc_pkg::SWC_ASLEEP) &&
               pending(control, 1'b1);
  end
  assign sleep_ok = sleep_seen && !sleep_nop && !ext_fall;
  assign wdt_wake = (state == swc_pkg::SWC_ASLEEP) && wdt_to_ev;
  assign wdt_reset = (state != swc_pkg::SWC_ASLEEP) && wdt_to_ev;
  assign wake = (wake_irq || wdt_wake) && !ext_fall;
  assign ost_start = wake &&
    needs_ost(control[swc_pkg::CTL_OSC_MSB:swc_pkg::CTL_OSC_LSB]);

  // Reset pin history for edge detection; high means released.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_prev <= 1'b1;
    end else begin
      ext_prev <= external_reset_pin_n;
    end
  end

  // ==========================================================
  // Sequencer.
  // A reset pin event wins over any wake source so that the core
  // restarts cleanly rather than resuming mid-sequence.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= swc_pkg::SWC_AWAKE;
    end else begin
      case (state)
        swc_pkg::SWC_AWAKE: begin
          if (sleep_ok && !wdt_reset) begin
            state <= swc_pkg::SWC_ASLEEP;
          end
        end
        swc_pkg::SWC_ASLEEP: begin
          if (ext_fall) begin
            state <= swc_pkg::SWC_AWAKE;
          end else if (ost_start) begin
            state <= swc_pkg::SWC_START_UP;
          end else if (wake) begin
            state <= swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_START_UP: begin
          if (ext_fall || wdt_reset) begin
            state <= swc_pkg::SWC_AWAKE;
          end else if (ost_done) begin
            state <= swc_pkg::SWC_RESUME;
          end
        end
        swc_pkg::SWC_RESUME: state <= swc_pkg::SWC_AWAKE;
        default: state <= swc_pkg::SWC_AWAKE;
      endcase
    end
  end

  swc_ost_timer u_ost (
    .clk(clk),
    .rst_n(rst_n),
    .start(ost_start),
    .done(ost_done)
  );
  // Port latch freezes while the sequencer sits in sleep.
  swc_port_hold u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .hold(state == swc_pkg::SWC_ASLEEP),
    .core_out(core_port_out),
    .core_oe(core_port_oe),
    .port_out(port_out),
    .port_oe(port_oe)
  );

  // ==========================================================
  // Clock and execution control.
  // The oscillator restarts at the wake event itself so that the
  // start-up delay overlaps the crystal's settling time.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_driver_on <= 1'b1;
      phase_clk_en <= 1'b1;
    end else begin
      if (sleep_ok && !wdt_reset) begin
        osc_driver_on <= 1'b0;
        phase_clk_en <= 1'b0;
      end else if (wake || ext_fall) begin
        osc_driver_on <= 1'b1;
      end
      if ((state == swc_pkg::SWC_RESUME) || ext_fall || wdt_reset) begin
        phase_clk_en <= 1'b1;
      end
    end
  end

  // Core strobes; each is a single-cycle pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prefetch_next <= 1'b0;
      resume_exec <= 1'b0;
      branch_to_vector <= 1'b0;
      wdt_clear <= 1'b0;
      device_reset_req <= 1'b0;
    end else begin
      prefetch_next <= sleep_seen;
      resume_exec <= (state == swc_pkg::SWC_RESUME);
      branch_to_vector <= (state == swc_pkg::SWC_RESUME) &&
                          global_irq_enable;
      wdt_clear <= sleep_ok || watchdog_clear_instr;
      device_reset_req <= ext_fall || wdt_reset;
    end
  end

  // ==========================================================
  // Status flags.
  // A time-out in the same cycle as a sleep leaves TO clear: the
  // time-out is the event software must be able to see.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_down_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end else begin
      if (sleep_ok) begin
        power_down_flag <= 1'b0;
      end else if (watchdog_clear_instr) begin
        power_down_flag <= 1'b1;
      end
      if (wdt_to_ev) begin
        timeout_flag <= 1'b0;
      end else if (sleep_ok || watchdog_clear_instr) begin
        timeout_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Event status and interrupt.
  assign evt_set = {ext_fall, wdt_reset, wake, sleep_ok};
  assign apb_access = psel && penable && pready;
  assign apb_write = apb_access && pwrite;
  assign evt_clr = (apb_write && (paddr == swc_pkg::ADDR_EVT_CLEAR)) ?
                   pwdata[swc_pkg::EVT_W-1:0] : '0;

  // Set wins over clear so no event is lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_status <= '0;
      irq <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      irq <= |(evt_status & evt_enable);
    end
  end

  // ==========================================================
  // APB slave.
  // One wait state: pready rises in the second access cycle.
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    case (paddr)
      swc_pkg::ADDR_CONTROL: next_rdata[swc_pkg::CTL_W-1:0] = control;
      swc_pkg::ADDR_STATE: begin
        next_rdata[swc_pkg::ST_PD] = power_down_flag;
        next_rdata[swc_pkg::ST_TO] = timeout_flag;
        next_rdata[swc_pkg::ST_ASLEEP] = (state == swc_pkg::SWC_ASLEEP);
        next_rdata[swc_pkg::ST_START] = (state == swc_pkg::SWC_START_UP);
      end
      swc_pkg::ADDR_EVT_STATUS: next_rdata[swc_pkg::EVT_W-1:0] = evt_status;
      swc_pkg::ADDR_EVT_CLEAR: next_rdata = '0;
      swc_pkg::ADDR_EVT_ENABLE: next_rdata[swc_pkg::EVT_W-1:0] = evt_enable;
      default: next_err = 1'b1;
    endcase
  end

  // Handshake and read data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_err;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // Writable registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control <= swc_pkg::CTL_RESET;
      evt_enable <= '0;
    end else if (apb_write) begin
      if (paddr == swc_pkg::ADDR_CONTROL) begin
        control <= pwdata[swc_pkg::CTL_W-1:0];
      end
      if (paddr == swc_pkg::ADDR_EVT_ENABLE) begin
        evt_enable <= pwdata[swc_pkg::EVT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Assertions.
  a_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_ok && !wdt_to_ev |=> !power_down_flag && timeout_flag &&
    wdt_clear && !osc_driver_on)
    else $error("sleep entry flags wrong");

  a_nop_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_nop && !watchdog_clear_instr && !wdt_to_ev |=>
    $stable(power_down_flag) && $stable(timeout_flag) && !wdt_clear &&
    state == swc_pkg::SWC_AWAKE)
    else $error("no-op sleep changed state");

  a_port_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state == swc_pkg::SWC_ASLEEP |=> $stable(port_out) &&
    $stable(port_oe))
    else $error("port moved in sleep");

  a_ext_reset: assert property (@(posedge clk) disable iff (!rst_n)
    state == swc_pkg::SWC_ASLEEP && ext_fall |=> device_reset_req ##1
    !resume_exec)
    else $error("reset pin did not reset");

  a_wdt_wake: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_wake && !ext_fall |=> !timeout_flag && !device_reset_req)
    else $error("watchdog wake mishandled");

  a_wdt_reset: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_reset |=> device_reset_req && !timeout_flag)
    else $error("awake time-out did not reset");

  a_ost_delay: assert property (@(posedge clk) disable iff (!rst_n)
    ost_start && state == swc_pkg::SWC_ASLEEP && !ext_fall |=>
    (state == swc_pkg::SWC_START_UP && !phase_clk_en)[*8])
    else $error("start-up delay skipped");

  a_rc_direct: assert property (@(posedge clk) disable iff (!rst_n)
    wake && !ost_start |=> state == swc_pkg::SWC_RESUME ##1
    resume_exec && phase_clk_en)
    else $error("rc wake not immediate");

  a_vector_sel: assert property (@(posedge clk) disable iff (!rst_n)
    state == swc_pkg::SWC_RESUME |=> resume_exec &&
    branch_to_vector == $past(global_irq_enable))
    else $error("vector choice wrong");

  a_adc_gate: assert property (@(posedge clk) disable iff (!rst_n)
    state == swc_pkg::SWC_ASLEEP && !adc_rc_clock && !edge_irq_flag &&
    !port_change_flag && !wdt_to_ev && !ext_fall |=>
    state == swc_pkg::SWC_ASLEEP)
    else $error("woke without source");

  a_prefetch: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_seen |=> prefetch_next)
    else $error("no prefetch on sleep");
endmodule // swc_top
`default_nettype wire

// >>> bench/swc_tb.sv
// Self-checking bench for the sleep and wake-up controller.
// Assumes the controller answers APB reads and writes within 16 cycles.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observed signals.
  logic clk;
  logic rst_n;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_instr;
  logic watchdog_clear_instr;
  logic wdt_timeout;
  logic global_irq_enable;
  logic external_reset_pin_n;
  logic edge_irq_flag;
  logic port_change_flag;
  logic adc_done_flag;
  logic adc_rc_clock;
  logic [swc_pkg::PORT_W-1:0] core_port_out;
  logic [swc_pkg::PORT_W-1:0] core_port_oe;
  logic [swc_pkg::PORT_W-1:0] port_out;
  logic [swc_pkg::PORT_W-1:0] port_oe;
  logic power_down_flag;
  logic timeout_flag;
  logic osc_driver_on;
  logic phase_clk_en;
  logic prefetch_next;
  logic resume_exec;
  logic branch_to_vector;
  logic wdt_clear;
  logic device_reset_req;
  logic irq;
  int n_fail; // Mismatches seen.
  int tests_run; // Comparisons made.
  int waited; // Cycles spent in the last wake wait.
  logic seen_rst; // A reset request showed during that wait.
  logic [31:0] rd; // Last APB read data.
  logic err; // Last APB error response.

  swc_top uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr),
    .wdt_timeout(wdt_timeout), .global_irq_enable(global_irq_enable),
    .external_reset_pin_n(external_reset_pin_n),
    .edge_irq_flag(edge_irq_flag), .port_change_flag(port_change_flag),
    .adc_done_flag(adc_done_flag), .adc_rc_clock(adc_rc_clock),
    .core_port_out(core_port_out), .core_port_oe(core_port_oe),
    .port_out(port_out), .port_oe(port_oe),
    .power_down_flag(power_down_flag), .timeout_flag(timeout_flag),
    .osc_driver_on(osc_driver_on), .phase_clk_en(phase_clk_en),
    .prefetch_next(prefetch_next), .resume_exec(resume_exec),
    .branch_to_vector(branch_to_vector), .wdt_clear(wdt_clear),
    .device_reset_req(device_reset_req), .irq(irq));

  // ==========================================================
  // Shared helpers.
  // The clock toggles every 20 ns, half of its 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compares a seen value to the expected one, four-state exact.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops; the only place the run ends.
  task automatic results();
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is sampled.
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) check(32'h0, 32'h1);
  endtask

  // Executes sleep; late raises the edge flag just after the strobe.
  task automatic enter_sleep(input logic late);
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    if (late) edge_irq_flag <= 1'b1;
    #1;
  endtask

  // Waits a bounded time for the resume pulse, noting reset requests.
  task automatic wait_resume(input int max);
    seen_rst = 1'b0;
    for (waited = 1; waited <= max; waited++) begin
      @(posedge clk);
      #1;
      if (device_reset_req === 1'b1) seen_rst = 1'b1;
      if (resume_exec === 1'b1) break;
    end
  endtask

  // One watchdog time-out pulse; samples just after it is taken.
  task automatic pulse_wdt();
    @(posedge clk);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Scenarios.
  // Reset values, register defaults and an unmapped address.
  task automatic t_reset();
    check(power_down_flag, 1'b1);
    check(osc_driver_on, 1'b1);
    apb(1'b0, swc_pkg::ADDR_CONTROL, 32'h0);
    check(rd, 32'h09);
    apb(1'b0, swc_pkg::ADDR_STATE, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, 8'h20, 32'hffffffff);
    check(err, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
  endtask

  // RC mode: entry effects, frozen ports, edge wake into the vector.
  task automatic t_rc_wake();
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h1c);
    core_port_out <= 6'h15;
    core_port_oe <= 6'h0f;
    enter_sleep(1'b0);
    check(prefetch_next, 1'b1);
    check(wdt_clear, 1'b1);
    check({power_down_flag, timeout_flag}, 2'b01);
    check({osc_driver_on, phase_clk_en}, 2'b00);
    core_port_out <= 6'h2a;
    core_port_oe <= 6'h30;
    apb(1'b0, swc_pkg::ADDR_STATE, 32'h0);
    check(rd, 32'h6);
    check({port_oe, port_out}, {6'h0f, 6'h15});
    check(phase_clk_en, 1'b0);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    edge_irq_flag <= 1'b1;
    wait_resume(8);
    check(resume_exec, 1'b1);
    check(branch_to_vector, 1'b1);
    check(seen_rst, 1'b0);
    check(waited <= 3, 1'b1);
    edge_irq_flag <= 1'b0;
    @(posedge clk);
    #1;
    check({osc_driver_on, phase_clk_en}, 2'b11);
    check({port_oe, port_out}, {6'h30, 6'h2a});
  endtask

  // Flag pending before sleep with global enable off: a no-operation.
  // Then a flag arriving just after the strobe: full sleep, quick wake.
  task automatic t_pending();
    @(posedge clk);
    watchdog_clear_instr <= 1'b1;
    global_irq_enable <= 1'b0;
    edge_irq_flag <= 1'b1;
    @(posedge clk);
    watchdog_clear_instr <= 1'b0;
    enter_sleep(1'b0);
    check(prefetch_next, 1'b1);
    check(wdt_clear, 1'b0);
    check({power_down_flag, timeout_flag}, 2'b11);
    check(phase_clk_en, 1'b1);
    edge_irq_flag <= 1'b0;
    enter_sleep(1'b1);
    check(wdt_clear, 1'b1);
    check({power_down_flag, timeout_flag}, 2'b01);
    wait_resume(8);
    check(resume_exec, 1'b1);
    check(branch_to_vector, 1'b0);
    check(waited <= 3, 1'b1);
    edge_irq_flag <= 1'b0;
  endtask

  // Watchdog time-out: wake while asleep, reset while awake.
  task automatic t_wdt();
    enter_sleep(1'b0);
    pulse_wdt();
    wait_resume(8);
    check(resume_exec, 1'b1);
    check(seen_rst, 1'b0);
    check(timeout_flag, 1'b0);
    pulse_wdt();
    check(device_reset_req, 1'b1);
    check(timeout_flag, 1'b0);
  endtask

  // A falling reset pin while asleep asks for a full reset.
  task automatic t_pin();
    enter_sleep(1'b0);
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    @(posedge clk);
    #1;
    check(device_reset_req, 1'b1);
    check(resume_exec, 1'b0);
    external_reset_pin_n <= 1'b1;
  endtask

  // Disabled edge flag and non-RC converter stay asleep; port change
  // and the RC-clocked converter wake.
  task automatic t_sources();
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h6c);
    adc_rc_clock <= 1'b0;
    enter_sleep(1'b0);
    edge_irq_flag <= 1'b1;
    adc_done_flag <= 1'b1;
    wait_resume(20);
    check(resume_exec, 1'b0);
    check(phase_clk_en, 1'b0);
    port_change_flag <= 1'b1;
    wait_resume(8);
    check(resume_exec, 1'b1);
    port_change_flag <= 1'b0;
    edge_irq_flag <= 1'b0;
    adc_done_flag <= 1'b0;
    adc_rc_clock <= 1'b1;
    enter_sleep(1'b0);
    adc_done_flag <= 1'b1;
    wait_resume(8);
    check(resume_exec, 1'b1);
    adc_done_flag <= 1'b0;
  endtask

  // Crystal mode waits the 1024-cycle start-up delay before resuming.
  task automatic t_xtal();
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h19);
    enter_sleep(1'b0);
    edge_irq_flag <= 1'b1;
    wait_resume(1200);
    check(resume_exec, 1'b1);
    check(waited >= 1024 && waited <= 1030, 1'b1);
    edge_irq_flag <= 1'b0;
  endtask

  // Sticky events, enable masking, level interrupt and clear.
  task automatic t_irq();
    apb(1'b0, swc_pkg::ADDR_EVT_STATUS, 32'h0);
    check(rd, 32'hf);
    check(irq, 1'b0);
    apb(1'b1, swc_pkg::ADDR_EVT_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    check(irq, 1'b1);
    apb(1'b1, swc_pkg::ADDR_EVT_CLEAR, 32'h1);
    apb(1'b0, swc_pkg::ADDR_EVT_STATUS, 32'h0);
    check(rd, 32'he);
    #1;
    check(irq, 1'b0);
  endtask

  // ==========================================================
  // Main sequence: every input has a value at time zero.
  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    sleep_instr = 1'b0;
    watchdog_clear_instr = 1'b0;
    wdt_timeout = 1'b0;
    global_irq_enable = 1'b0;
    external_reset_pin_n = 1'b1;
    edge_irq_flag = 1'b0;
    port_change_flag = 1'b0;
    adc_done_flag = 1'b0;
    adc_rc_clock = 1'b0;
    core_port_out = 6'h00;
    core_port_oe = 6'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_rc_wake();
    t_pending();
    t_wdt();
    t_pin();
    t_sources();
    t_xtal();
    t_irq();
    results();
  end

  // Cuts a hang short; the tests need about 1,150 cycles.
  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule // testbench
`default_nettype wire
